// File: include/oft_pkg.sv
`default_nettype none
package oft_pkg;
   // Register indices; the bus byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_MCTRL = 8'h04;
   localparam logic [7:0] IDX_MADDR = 8'h06;
   localparam logic [7:0] IDX_LOCK = 8'h08;
   localparam logic [7:0] IDX_MDATA = 8'h0C;
   localparam logic [7:0] IDX_MEM = 8'h10;
   localparam int ADDR_W = 12;
   localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
   localparam logic [11:0] A_MCTRL = {2'b00, IDX_MCTRL, 2'b00};
   localparam logic [11:0] A_MADDR = {2'b00, IDX_MADDR, 2'b00};
   localparam logic [11:0] A_LOCK = {2'b00, IDX_LOCK, 2'b00};
   localparam logic [11:0] A_MDATA = {2'b00, IDX_MDATA, 2'b00};
   localparam logic [11:0] A_MEM = {2'b00, IDX_MEM, 2'b00};
   localparam logic [11:0] MEM_SPAN = 12'h400;
   localparam logic [11:0] A_MEM_END = A_MEM + MEM_SPAN;

   // Control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SUPP_BIT = 3;
   localparam int CTRL_SUPR_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   // Manual control fields
   localparam int MCTRL_SEL_BIT = 0;
   localparam int MCTRL_PULSE_BIT = 1;
   // Manual address fields
   localparam int MADDR_OFS_LSB = 0;
   localparam int MADDR_BLK_LSB = 10;
   // Manual data / status fields, status bits are write-one-to-clear
   localparam int MDATA_FUSE_BIT = 0;
   localparam int ST_SUPPLY_BIT = 8;
   localparam int ST_TIMING_BIT = 9;
   localparam int ST_LOCKREJ_BIT = 10;

   // Array geometry
   localparam int BLOCKS = 4;
   localparam int FUSE_BITS = 4096;
   localparam int LOCKS = 4;

   // Region upper byte bounds; the top region runs to the last byte
   localparam logic [8:0] REG0_HI = 9'h01F;
   localparam logic [8:0] REG1_HI = 9'h07F;
   localparam logic [8:0] REG2_HI = 9'h0BF;
   // Debug configuration byte and its bits
   localparam logic [8:0] DBG_BYTE = 9'h1E2;
   localparam int DBG_SWD_BIT = 6;
   localparam int DBG_DIS_BIT = 7;

   // Programming timing
   localparam int CLK_MHZ = 40;
   localparam int T_SETUP_NS = 100;
   localparam int T_RECOV_NS = 100;
   localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOV_CYC = (T_RECOV_NS * CLK_MHZ + 999) / 1000;
   localparam int AGE_W = 4;

   typedef struct packed {
      logic [1:0] block;
      logic [9:0] offset;
   } oft_faddr_s;

   typedef struct packed {
      logic [3:0] block_pwr;
      logic strobe;
      oft_faddr_s addr;
   } oft_fuse_drv_s;

   typedef enum logic {OFT_BUS_IDLE, OFT_BUS_READ} oft_bus_e;
endpackage
`default_nettype wire

// File: hw/oft_fuse_ctrl.sv
// Contract
// - Block number is written while deselected and picks the targeted block.
// - Selecting the array powers only the block named by the block number.
// - Bit offset field directs the next programming pulse to that bit.
// - Program and read supply bits never change in one write.
// - After reset control reads 0x10, only read supply connected.
// - Locked region rejects programming and reads as zero.
// - Region byte bounds are parameters; key region lowest, vendor next.
// - Byte 482 bit 6 selects serial debug, bit 7 disables debug.
// - Programming only sets bits; a one stays one.
// - Program address is 2-bit block plus 10-bit offset, bit by bit.
// - Reads give 16-bit value replicated into upper byte lanes.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module oft_fuse_ctrl #(
   parameter logic [8:0] REG0_HI = oft_pkg::REG0_HI,
   parameter logic [8:0] REG1_HI = oft_pkg::REG1_HI,
   parameter logic [8:0] REG2_HI = oft_pkg::REG2_HI
) (
   input wire logic ref_clk, // System clock, 40 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, whole words only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic [31:0] hrdata, // AHB read data
   output logic hresp, // AHB response, always OKAY
   output oft_pkg::oft_fuse_drv_s fuse_drv, // Block power, strobe and bit address
   output logic supply_connect_program, // Program supply switch
   output logic supply_connect_read, // Read supply switch
   output logic debug_swd_sel, // Serial debug port selected
   output logic debug_disable // Both debug ports disabled
);
   logic ctrl_en_reg;
   logic sup_prog_reg;
   logic sup_read_reg;
   logic sel_reg;
   logic pulse_reg;
   oft_pkg::oft_faddr_s faddr_reg;
   logic [oft_pkg::LOCKS-1:0] lock_reg;
   logic supply_err_reg;
   logic timing_err_reg;
   logic lock_rej_reg;
   logic [oft_pkg::AGE_W-1:0] addr_age_reg;
   logic [oft_pkg::AGE_W-1:0] low_age_reg;
   logic [oft_pkg::FUSE_BITS-1:0] fuse_bits = '0; // Unblown fuses read as zero; reset leaves them alone
   oft_pkg::oft_bus_e bus_reg;
   logic wr_pend_reg;
   logic [oft_pkg::ADDR_W-1:0] wr_addr_reg;
   logic [oft_pkg::ADDR_W-1:0] rd_addr_reg;
   logic [31:0] hrdata_reg;
   logic hready_reg;
   oft_pkg::oft_fuse_drv_s drv_reg;
   logic dbg_swd_reg;
   logic dbg_dis_reg;

   logic addr_phase;
   logic wr_ctrl, wr_mctrl, wr_maddr, wr_lock, wr_mdata;
   logic [8:0] tgt_byte;
   logic tgt_locked;
   logic pulse_rise, pulse_fall;
   logic timing_viol;
   logic supply_both;
   logic rd_is_mem;
   logic [7:0] mem_k;
   logic rd_lo_locked, rd_hi_locked;
   logic [31:0] rd_value;

   function automatic logic [1:0] region_of(input logic [8:0] bi);
      if (bi <= REG0_HI) region_of = 2'd0;
      else if (bi <= REG1_HI) region_of = 2'd1;
      else if (bi <= REG2_HI) region_of = 2'd2;
      else region_of = 2'd3;
   endfunction

   function automatic logic region_locked(input logic [8:0] bi);
      region_locked = lock_reg[region_of(bi)];
   endfunction

   function automatic logic [7:0] fuse_byte(input logic [8:0] bi);
      fuse_byte = fuse_bits[{bi, 3'b000} +: 8];
      if (!ctrl_en_reg || region_locked(bi)) fuse_byte = 8'h00;
   endfunction

   // Bus decode
   assign addr_phase = hsel && htrans[1] && hready;
   assign wr_ctrl = wr_pend_reg && (wr_addr_reg == oft_pkg::A_CTRL);
   assign wr_mctrl = wr_pend_reg && (wr_addr_reg == oft_pkg::A_MCTRL);
   assign wr_maddr = wr_pend_reg && (wr_addr_reg == oft_pkg::A_MADDR);
   assign wr_lock = wr_pend_reg && (wr_addr_reg == oft_pkg::A_LOCK);
   assign wr_mdata = wr_pend_reg && (wr_addr_reg == oft_pkg::A_MDATA);

   assign tgt_byte = {faddr_reg.block, faddr_reg.offset[9:3]};
   always_comb tgt_locked = region_locked(tgt_byte); // Must also wake on lock writes, not only address changes
   assign pulse_rise = wr_mctrl && hwdata[oft_pkg::MCTRL_PULSE_BIT] && !pulse_reg;
   assign pulse_fall = wr_mctrl && !hwdata[oft_pkg::MCTRL_PULSE_BIT] && pulse_reg;
   assign timing_viol = (pulse_rise && (addr_age_reg < oft_pkg::AGE_W'(oft_pkg::SETUP_CYC)
                         || low_age_reg < oft_pkg::AGE_W'(oft_pkg::RECOV_CYC)))
                        || (wr_maddr && (pulse_reg || low_age_reg < oft_pkg::AGE_W'(oft_pkg::RECOV_CYC)));
   assign supply_both = wr_ctrl && (hwdata[oft_pkg::CTRL_SUPP_BIT] != sup_prog_reg)
                        && (hwdata[oft_pkg::CTRL_SUPR_BIT] != sup_read_reg);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bus_reg <= oft_pkg::OFT_BUS_IDLE;
         hready_reg <= 1'b1;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         rd_addr_reg <= '0;
         hrdata_reg <= '0;
      end else begin
         unique case (bus_reg)
            oft_pkg::OFT_BUS_IDLE: begin
               if (hready) begin
                  wr_pend_reg <= addr_phase && hwrite;
                  wr_addr_reg <= haddr[oft_pkg::ADDR_W-1:0];
               end
               if (addr_phase && !hwrite) begin
                  bus_reg <= oft_pkg::OFT_BUS_READ;
                  rd_addr_reg <= haddr[oft_pkg::ADDR_W-1:0];
                  hready_reg <= 1'b0;
               end
            end
            oft_pkg::OFT_BUS_READ: begin
               hrdata_reg <= rd_value;
               hready_reg <= 1'b1;
               bus_reg <= oft_pkg::OFT_BUS_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      rd_is_mem = (rd_addr_reg >= oft_pkg::A_MEM) && (rd_addr_reg < oft_pkg::A_MEM_END);
      mem_k = 8'((rd_addr_reg - oft_pkg::A_MEM) >> 2);
      rd_lo_locked = region_locked({mem_k, 1'b0});
      rd_hi_locked = region_locked({mem_k, 1'b1});
      rd_value = '0;
      if (rd_is_mem) begin
         rd_value[15:0] = {fuse_byte({mem_k, 1'b1}), fuse_byte({mem_k, 1'b0})};
         rd_value[31:16] = rd_value[15:0];
      end else begin
         unique case (rd_addr_reg)
            oft_pkg::A_CTRL: begin
               rd_value[oft_pkg::CTRL_EN_BIT] = ctrl_en_reg;
               rd_value[oft_pkg::CTRL_SUPP_BIT] = sup_prog_reg;
               rd_value[oft_pkg::CTRL_SUPR_BIT] = sup_read_reg;
            end
            oft_pkg::A_MCTRL: begin
               rd_value[oft_pkg::MCTRL_SEL_BIT] = sel_reg;
               rd_value[oft_pkg::MCTRL_PULSE_BIT] = pulse_reg;
            end
            oft_pkg::A_MADDR: begin
               rd_value[oft_pkg::MADDR_OFS_LSB +: 10] = faddr_reg.offset;
               rd_value[oft_pkg::MADDR_BLK_LSB +: 2] = faddr_reg.block;
            end
            oft_pkg::A_LOCK: rd_value[oft_pkg::LOCKS-1:0] = lock_reg;
            oft_pkg::A_MDATA: begin
               rd_value[oft_pkg::MDATA_FUSE_BIT] = fuse_bits[{faddr_reg.block, faddr_reg.offset}] && !tgt_locked;
               rd_value[oft_pkg::ST_SUPPLY_BIT] = supply_err_reg;
               rd_value[oft_pkg::ST_TIMING_BIT] = timing_err_reg;
               rd_value[oft_pkg::ST_LOCKREJ_BIT] = lock_rej_reg;
            end
            default: rd_value = '0;
         endcase
      end
   end

   // Control register; a write moving both supply bits changes neither
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl_en_reg <= oft_pkg::CTRL_RESET[oft_pkg::CTRL_EN_BIT];
         sup_prog_reg <= oft_pkg::CTRL_RESET[oft_pkg::CTRL_SUPP_BIT];
         sup_read_reg <= oft_pkg::CTRL_RESET[oft_pkg::CTRL_SUPR_BIT];
      end else if (wr_ctrl) begin
         ctrl_en_reg <= hwdata[oft_pkg::CTRL_EN_BIT];
         if (!supply_both) begin
            sup_prog_reg <= hwdata[oft_pkg::CTRL_SUPP_BIT];
            sup_read_reg <= hwdata[oft_pkg::CTRL_SUPR_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sel_reg <= 1'b0;
         pulse_reg <= 1'b0;
         faddr_reg <= '0;
      end else begin
         if (wr_mctrl) begin
            sel_reg <= hwdata[oft_pkg::MCTRL_SEL_BIT];
            pulse_reg <= hwdata[oft_pkg::MCTRL_PULSE_BIT];
         end
         if (wr_maddr) begin
            faddr_reg.offset <= hwdata[oft_pkg::MADDR_OFS_LSB +: 10];
            if (!sel_reg) faddr_reg.block <= hwdata[oft_pkg::MADDR_BLK_LSB +: 2];
         end
      end
   end

   // Locks only set; cleared by reset alone
   always_ff @(posedge ref_clk) begin
      if (srst) lock_reg <= '0;
      else if (wr_lock) lock_reg <= lock_reg | hwdata[oft_pkg::LOCKS-1:0];
   end

   // Setup and recovery ages for the timing check
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         addr_age_reg <= oft_pkg::AGE_W'(oft_pkg::SETUP_CYC);
         low_age_reg <= oft_pkg::AGE_W'(oft_pkg::RECOV_CYC);
      end else begin
         if (wr_maddr) addr_age_reg <= '0;
         else if (addr_age_reg < oft_pkg::AGE_W'(oft_pkg::SETUP_CYC)) addr_age_reg <= addr_age_reg + 1'b1;
         if (pulse_fall || pulse_reg) low_age_reg <= '0;
         else if (low_age_reg < oft_pkg::AGE_W'(oft_pkg::RECOV_CYC)) low_age_reg <= low_age_reg + 1'b1;
      end
   end

   // Sticky status, set wins over write-one clear
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         supply_err_reg <= 1'b0;
         timing_err_reg <= 1'b0;
         lock_rej_reg <= 1'b0;
      end else begin
         supply_err_reg <= supply_both || (supply_err_reg && !(wr_mdata && hwdata[oft_pkg::ST_SUPPLY_BIT]));
         timing_err_reg <= timing_viol || (timing_err_reg && !(wr_mdata && hwdata[oft_pkg::ST_TIMING_BIT]));
         lock_rej_reg <= (pulse_rise && tgt_locked)
                         || (lock_rej_reg && !(wr_mdata && hwdata[oft_pkg::ST_LOCKREJ_BIT]));
      end
   end

   // Drive to the array
   always_ff @(posedge ref_clk) begin
      if (srst) drv_reg <= '0;
      else begin
         drv_reg.block_pwr <= sel_reg ? (4'b0001 << faddr_reg.block) : 4'b0000;
         drv_reg.strobe <= pulse_reg && sel_reg && sup_prog_reg && !tgt_locked;
         drv_reg.addr <= faddr_reg;
      end
   end

   // Fuse array model: a strobe can only blow a bit
   always_ff @(posedge ref_clk) begin
      if (drv_reg.strobe) fuse_bits[drv_reg.addr] <= 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dbg_swd_reg <= 1'b0;
         dbg_dis_reg <= 1'b0;
      end else begin
         dbg_swd_reg <= fuse_bits[{oft_pkg::DBG_BYTE, 3'(oft_pkg::DBG_SWD_BIT)}];
         dbg_dis_reg <= fuse_bits[{oft_pkg::DBG_BYTE, 3'(oft_pkg::DBG_DIS_BIT)}];
      end
   end

   assign hreadyout = hready_reg;
   assign hrdata = hrdata_reg;
   assign hresp = 1'b0;
   assign fuse_drv = drv_reg;
   assign supply_connect_program = sup_prog_reg;
   assign supply_connect_read = sup_read_reg;
   assign debug_swd_sel = dbg_swd_reg;
   assign debug_disable = dbg_dis_reg;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_block_hold_sel: assert property (wr_maddr && sel_reg |=> $stable(faddr_reg.block))
      else $error("block number changed while selected");
   a_block_power_one: assert property (1'b1 |=> drv_reg.block_pwr ==
      ($past(sel_reg) ? (4'b0001 << $past(faddr_reg.block)) : 4'b0000))
      else $error("block power does not match selection");
   a_offset_follow: assert property (wr_maddr |=> faddr_reg.offset == $past(hwdata[9:0]))
      else $error("bit offset not taken");
   a_supply_split: assert property (!$past(srst) && $changed(sup_prog_reg) |-> $stable(sup_read_reg))
      else $error("both supply bits changed together");
   a_strobe_gate: assert property (drv_reg.strobe |-> $past(sel_reg && sup_prog_reg && pulse_reg))
      else $error("strobe without select and program supply");
   a_lock_no_strobe: assert property (drv_reg.strobe |-> !$past(tgt_locked))
      else $error("strobe into locked region");
   a_fuse_sticky: assert property (($past(fuse_bits) & ~fuse_bits) == '0)
      else $error("fuse bit returned to zero");
   a_strobe_blows: assert property (drv_reg.strobe |=> fuse_bits[$past(drv_reg.addr)])
      else $error("strobed bit not set");
   a_locked_read_zero: assert property (bus_reg == oft_pkg::OFT_BUS_READ && rd_is_mem
      && rd_lo_locked && rd_hi_locked |=> hrdata_reg == '0 && hready_reg)
      else $error("locked region read not zero");
   a_read_replicate: assert property (bus_reg == oft_pkg::OFT_BUS_READ && rd_is_mem
      |=> hrdata_reg[31:16] == hrdata_reg[15:0])
      else $error("upper lanes not replicated");
   a_disabled_read_zero: assert property (bus_reg == oft_pkg::OFT_BUS_READ && rd_is_mem && !ctrl_en_reg
      |=> hrdata_reg == '0)
      else $error("read data while disabled");
   a_reset_ctrl_val: assert property ($fell(srst) |-> sup_read_reg && !sup_prog_reg && !ctrl_en_reg)
      else $error("control not at reset value");
   a_debug_follow: assert property (!$past(srst) |-> debug_disable ==
      $past(fuse_bits[{oft_pkg::DBG_BYTE, 3'(oft_pkg::DBG_DIS_BIT)}]))
      else $error("debug disable not from fuse");

   c_bit_blown: cover property (drv_reg.strobe ##1 !drv_reg.strobe);
   c_supply_reject: cover property (supply_both);
   c_mem_read: cover property (bus_reg == oft_pkg::OFT_BUS_READ && rd_is_mem && ctrl_en_reg);
   c_lock_reject: cover property (pulse_rise && tgt_locked);
endmodule
`default_nettype wire

// File: tb/oft_fuse_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module oft_fuse_ctrl_bench;
   typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d;} oft_row_s;
   logic ref_clk, srst, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, supply_connect_program, supply_connect_read, debug_swd_sel, debug_disable;
   oft_pkg::oft_fuse_drv_s fuse_drv;
   wire logic hready = hreadyout;
   int mismatches, cmp_count;
   oft_row_s rows [12];

   oft_fuse_ctrl oft_fuse_ctrl_inst (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .fuse_drv(fuse_drv), .supply_connect_program(supply_connect_program),
      .supply_connect_read(supply_connect_read), .debug_swd_sel(debug_swd_sel), .debug_disable(debug_disable));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // hready only moves on a rising edge, so its value at the falling edge is what the next rising edge samples
   task automatic wait_ready(output logic [31:0] d);
      int n;
      logic r;
      n = 0;
      r = 1'b0;
      d = '0;
      while (!r) begin
         @(negedge ref_clk);
         r = (hready === 1'b1);
         d = hrdata;
         @(posedge ref_clk);
         n++;
         if (n > 50) begin
            mismatches++;
            $display("BAD %0t bus wait expired", $time);
            report_and_stop();
         end
      end
   endtask

   // Called just after a rising edge; returns just after the edge that ends the data phase
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsel <= 1'b1;
      wait_ready(d);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready(d);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      xfer(1'b0, a, 32'h0000_0000, d);
      chk(d, exp, what);
   endtask

   task automatic prog_bit(input logic [1:0] b, input logic [9:0] o, input logic exp_stb);
      logic [31:0] d;
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0000, d);
      xfer(1'b1, oft_pkg::A_MADDR, {20'h0_0000, b, o}, d);
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0001, d);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({28'h000_0000, fuse_drv.block_pwr}, {28'h000_0000, 4'b0001 << b}, "block power");
      chk({20'h0_0000, fuse_drv.addr}, {20'h0_0000, b, o}, "fuse address");
      @(posedge ref_clk);
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0003, d);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({31'h0, fuse_drv.strobe}, {31'h0, exp_stb}, "strobe");
      @(posedge ref_clk);
      repeat (400) @(posedge ref_clk);
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0001, d);
      repeat (4) @(posedge ref_clk);
   endtask

   function automatic logic [11:0] win(input int byte_i);
      return oft_pkg::A_MEM + 12'((byte_i / 2) * 4);
   endfunction

   initial begin
      mismatches = 0;
      cmp_count = 0;
      srst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      rows = '{'{1'b0, oft_pkg::A_CTRL, 32'h0000_0010}, '{1'b0, 12'h004, 32'h0000_0000},
         '{1'b1, 12'h004, 32'hFFFF_FFFF}, '{1'b0, 12'h004, 32'h0000_0000},
         '{1'b1, oft_pkg::A_CTRL, 32'h0000_0009}, '{1'b0, oft_pkg::A_CTRL, 32'h0000_0011},
         '{1'b0, oft_pkg::A_MDATA, 32'h0000_0100}, '{1'b1, oft_pkg::A_MDATA, 32'h0000_0100},
         '{1'b0, oft_pkg::A_MDATA, 32'h0000_0000}, '{1'b1, oft_pkg::A_CTRL, 32'h0000_0001},
         '{1'b1, oft_pkg::A_CTRL, 32'h0000_0009}, '{1'b0, oft_pkg::A_CTRL, 32'h0000_0009}};
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      chk({hreadyout, hresp, supply_connect_read, supply_connect_program}, 32'h0000_000A, "reset pins");
      chk({15'h0000, fuse_drv}, 32'h0000_0000, "reset fuse drive");
      @(posedge ref_clk);
      // Register access table: unmapped place, refused double supply change, sticky status
      foreach (rows[i]) begin
         xfer(rows[i].wr, rows[i].a, rows[i].d, rd);
         if (!rows[i].wr) chk(rd, rows[i].d, "table read");
      end
      @(negedge ref_clk);
      chk({supply_connect_program, supply_connect_read}, 32'h0000_0002, "program supply");
      @(posedge ref_clk);
      prog_bit(2'd1, 10'd504, 1'b1);
      rchk(oft_pkg::A_MDATA, 32'h0000_0001, "bit set");
      prog_bit(2'd1, 10'd512, 1'b1);
      // Block change while selected keeps the old block, offset still taken
      xfer(1'b1, oft_pkg::A_MADDR, 32'h0000_0C09, rd);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({20'h0_0000, fuse_drv.addr}, 32'h0000_0409, "block kept");
      @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      prog_bit(2'd3, 10'd790, 1'b1);
      prog_bit(2'd3, 10'd791, 1'b1);
      @(negedge ref_clk);
      chk({debug_swd_sel, debug_disable}, 32'h0000_0003, "debug pins");
      @(posedge ref_clk);
      rchk(win(190), 32'h0100_0100, "bytes 190 191");
      rchk(win(192), 32'h0001_0001, "bytes 192 193");
      rchk(win(482), 32'h00C0_00C0, "bytes 482 483");
      xfer(1'b1, oft_pkg::A_CTRL, 32'h0000_0008, rd);
      rchk(win(192), 32'h0000_0000, "disabled read");
      xfer(1'b1, oft_pkg::A_CTRL, 32'h0000_0009, rd);
      xfer(1'b1, oft_pkg::A_LOCK, 32'h0000_0008, rd);
      rchk(win(192), 32'h0000_0000, "locked read");
      rchk(win(190), 32'h0100_0100, "open neighbour");
      xfer(1'b1, oft_pkg::A_LOCK, 32'h0000_0000, rd);
      rchk(oft_pkg::A_LOCK, 32'h0000_0008, "lock kept");
      prog_bit(2'd1, 10'd520, 1'b0);
      rchk(oft_pkg::A_MDATA, 32'h0000_0400, "locked reject");
      // Power down, then a pulse without program supply must not reach the array
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0000, rd);
      xfer(1'b1, oft_pkg::A_CTRL, 32'h0000_0001, rd);
      xfer(1'b1, oft_pkg::A_CTRL, 32'h0000_0011, rd);
      @(negedge ref_clk);
      chk({supply_connect_program, supply_connect_read}, 32'h0000_0001, "read supply");
      @(posedge ref_clk);
      prog_bit(2'd0, 10'd300, 1'b0);
      rchk(win(37), 32'h0000_0000, "no supply no blow");
      // Pulse raised two cycles after addressing is flagged; lock reject is still sticky
      xfer(1'b1, oft_pkg::A_MADDR, 32'h0000_012C, rd);
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0003, rd);
      xfer(1'b1, oft_pkg::A_MCTRL, 32'h0000_0001, rd);
      rchk(oft_pkg::A_MDATA, 32'h0000_0600, "early pulse flagged");
      // Second reset: fuses survive, debug pins follow them again
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({debug_swd_sel, debug_disable}, 32'h0000_0000, "debug in reset");
      @(posedge ref_clk);
      srst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({debug_swd_sel, debug_disable}, 32'h0000_0003, "debug kept");
      @(posedge ref_clk);
      rchk(oft_pkg::A_CTRL, 32'h0000_0010, "ctrl after reset");
      report_and_stop();
   end
endmodule
`default_nettype wire
